// file: logic/csp_alu.sv
// arithmetic core: add, add with carry, subtract with borrow, multiply, divide
`timescale 1ns/10ps
`default_nettype none
module csp_alu (
    input  wire logic            [7:0] acc,
    input  wire logic            [7:0] aux,
    input  wire logic            [7:0] operand,
    input  wire logic                  cy_in,
    input  wire logic                  ac_in,
    input  wire logic                  ov_in,
    input  wire csp_pkg::csp_op_e      op,
    output logic                 [7:0] res_a,
    output logic                 [7:0] res_b,
    output logic                       cy_out,
    output logic                       ac_out,
    output logic                       ov_out
);
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic [15:0] prod;
    logic        cin;

    always_comb begin
        sum    = 9'h000;
        nib    = 5'h00;
        prod   = 16'h0000;
        cin    = 1'b0;
        res_a  = acc;
        res_b  = aux;
        cy_out = cy_in;
        ac_out = ac_in;
        ov_out = ov_in;
        case (op)
            csp_pkg::CSP_OP_ADD, csp_pkg::CSP_OP_ADDC: begin
                cin    = (op == csp_pkg::CSP_OP_ADDC) & cy_in;
                sum    = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
                nib    = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
                res_a  = sum[7:0];
                cy_out = sum[8];
                ac_out = nib[4];
                ov_out = (acc[7] == operand[7]) && (sum[7] != acc[7]);
            end
            csp_pkg::CSP_OP_SUBB: begin
                sum    = {1'b0, acc} - {1'b0, operand} - {8'h00, cy_in};
                nib    = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cy_in};
                res_a  = sum[7:0];
                cy_out = sum[8];
                ac_out = nib[4];
                ov_out = (acc[7] != operand[7]) && (sum[7] != acc[7]);
            end
            csp_pkg::CSP_OP_MUL: begin
                prod   = {8'h00, acc} * {8'h00, aux};
                res_a  = prod[7:0];
                res_b  = prod[15:8];
                cy_out = 1'b0;
                ac_out = 1'b0;
                ov_out = |prod[15:8];
            end
            csp_pkg::CSP_OP_DIV: begin
                cy_out = 1'b0;
                ac_out = 1'b0;
                // divide by zero leaves both operands untouched
                ov_out = (aux == 8'h00);
                if (aux != 8'h00) begin
                    res_a = acc / aux;
                    res_b = acc % aux;
                end
            end
            default: begin
                res_a = acc;
            end
        endcase
    end
endmodule // csp_alu
`default_nettype wire

// file: logic/csp_pkg.sv
// types shared by the cpu status block
package csp_pkg;
    typedef enum logic [3:0] {
        CSP_OP_NONE, CSP_OP_ADD, CSP_OP_ADDC, CSP_OP_SUBB, CSP_OP_MUL, CSP_OP_DIV,
        CSP_OP_PUSH, CSP_OP_POP, CSP_OP_CLR_C, CSP_OP_SET_C, CSP_OP_CPL_C,
        CSP_OP_ANL_C, CSP_OP_ORL_C, CSP_OP_MOV_C, CSP_OP_INC_DP, CSP_OP_LOAD_DP
    } csp_op_e;

    typedef enum logic [2:0] {
        CSP_SEL_NONE, CSP_SEL_STATUS, CSP_SEL_MAIN, CSP_SEL_AUX,
        CSP_SEL_STACK, CSP_SEL_DP_LO, CSP_SEL_DP_HI, CSP_SEL_DP_16
    } csp_sel_e;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  aux;
        logic [7:0]  sp;
        logic [7:0]  data_pointer_high_byte;
        logic [7:0]  data_pointer_low_byte;
        logic        cy;
        logic        ac;
        logic        f0;
        logic [1:0]  rs;
        logic        ov;
        logic        f1;
        logic        par;
        logic [31:0] prdata;
        logic [7:0]  wreg_addr;
        logic [7:0]  stack_addr;
        logic        stack_wr;
        logic        stack_rd;
        logic        live;
    } csp_state_s;
endpackage

// file: logic/csp_regs.svh
// register indices, field positions, reset values of the cpu status block
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CSP_IDX_STACK     8'h81
`define CSP_IDX_DP_LO     8'h82
`define CSP_IDX_DP_HI     8'h83
`define CSP_IDX_DP_16     8'h84
`define CSP_IDX_STATUS    8'hd0
`define CSP_IDX_MAIN      8'he0
`define CSP_IDX_AUX       8'hf0
// ----------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------
`define CSP_BIT_CARRY     7
`define CSP_BIT_HALF      6
`define CSP_BIT_USER0     5
`define CSP_BIT_BANK_HI   4
`define CSP_BIT_BANK_LO   3
`define CSP_BIT_RANGE     2
`define CSP_BIT_USER1     1
`define CSP_BIT_PARITY    0
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSP_STACK_RESET   8'h07
`define CSP_BYTE_RESET    8'h00
`endif

// file: logic/csp_top.sv
// cpu status word, stack pointer, data pointer and operand registers on apb
//
// Contract
// - stack pointer 8 bits, incremented before push
// - reset puts stack pointer at 07h
// - stack anywhere in ram, up to 256 bytes
// - data pointer 16 bits, also two bytes
// - aux register holds multiply/divide operand, result
// - carry set on carry/borrow, else cleared
// - carry is the boolean one-bit accumulator
// - half carry tracks nibble carry or borrow
// - bank bits pick 00h, 08h, 10h, 18h
// - add/subtract sign overflow sets range flag
// - product above 255 sets range flag
// - divide by zero sets range flag
// - otherwise these instructions clear range flag
// - parity follows odd ones count of accumulator
// - two user flags are plain storage
// - status word at d0h, documented bit order
`timescale 1ns/10ps
`include "csp_regs.svh"
`default_nettype none
module csp_top #(
    parameter int ADDR_W = 10
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              op_valid,
    input  wire csp_pkg::csp_op_e  op_kind,
    input  wire logic [7:0]        op_operand,
    input  wire logic              op_bit,
    input  wire logic [15:0]       op_addr16,
    input  wire logic [2:0]        reg_index,
    output logic      [7:0]        acc_out,
    output logic      [7:0]        aux_out,
    output logic      [7:0]        status_word,
    output logic                   carry_flag,
    output logic      [15:0]       data_pointer_16_out,
    output logic      [7:0]        stack_ptr,
    output logic      [7:0]        stack_addr,
    output logic                   stack_wr,
    output logic                   stack_rd,
    output logic      [7:0]        wreg_addr
);
    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic csp_pkg::csp_sel_e decode(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'b00) begin
            decode = csp_pkg::CSP_SEL_NONE;
        end else if (idx == `CSP_IDX_STATUS) begin
            decode = csp_pkg::CSP_SEL_STATUS;
        end else if (idx == `CSP_IDX_MAIN) begin
            decode = csp_pkg::CSP_SEL_MAIN;
        end else if (idx == `CSP_IDX_AUX) begin
            decode = csp_pkg::CSP_SEL_AUX;
        end else if (idx == `CSP_IDX_STACK) begin
            decode = csp_pkg::CSP_SEL_STACK;
        end else if (idx == `CSP_IDX_DP_LO) begin
            decode = csp_pkg::CSP_SEL_DP_LO;
        end else if (idx == `CSP_IDX_DP_HI) begin
            decode = csp_pkg::CSP_SEL_DP_HI;
        end else if (idx == `CSP_IDX_DP_16) begin
            decode = csp_pkg::CSP_SEL_DP_16;
        end else begin
            decode = csp_pkg::CSP_SEL_NONE;
        end
    endfunction

    function automatic logic [7:0] pack_status(input csp_pkg::csp_state_s s);
        pack_status = {s.cy, s.ac, s.f0, s.rs, s.ov, s.f1, s.par};
    endfunction

    function automatic logic [31:0] read_word(input csp_pkg::csp_state_s s,
                                              input csp_pkg::csp_sel_e sel);
        case (sel)
            csp_pkg::CSP_SEL_STATUS: read_word = {24'h000000, pack_status(s)};
            csp_pkg::CSP_SEL_MAIN:   read_word = {24'h000000, s.acc};
            csp_pkg::CSP_SEL_AUX:    read_word = {24'h000000, s.aux};
            csp_pkg::CSP_SEL_STACK:  read_word = {24'h000000, s.sp};
            csp_pkg::CSP_SEL_DP_LO:  read_word = {24'h000000, s.data_pointer_low_byte};
            csp_pkg::CSP_SEL_DP_HI:  read_word = {24'h000000, s.data_pointer_high_byte};
            csp_pkg::CSP_SEL_DP_16:  read_word = {16'h0000, s.data_pointer_high_byte, s.data_pointer_low_byte};
            default:                 read_word = 32'h00000000;
        endcase
    endfunction

    // bank number times eight plus register index
    function automatic logic [7:0] bank_addr(input logic [1:0] rs, input logic [2:0] n);
        bank_addr = {3'b000, rs, n};
    endfunction

    // ------------------------------------------------------------------
    // state and arithmetic core
    // ------------------------------------------------------------------
    csp_pkg::csp_state_s st_r;
    csp_pkg::csp_state_s st_nxt;
    csp_pkg::csp_sel_e   sel;
    logic                setup;
    logic                sw_wr;
    logic [7:0]          alu_a;
    logic [7:0]          alu_b;
    logic                alu_cy;
    logic                alu_ac;
    logic                alu_ov;
    logic [15:0]         dp_inc;

    csp_alu u_alu (
        .acc     (st_r.acc),
        .aux     (st_r.aux),
        .operand (op_operand),
        .cy_in   (st_r.cy),
        .ac_in   (st_r.ac),
        .ov_in   (st_r.ov),
        .op      (op_kind),
        .res_a   (alu_a),
        .res_b   (alu_b),
        .cy_out  (alu_cy),
        .ac_out  (alu_ac),
        .ov_out  (alu_ov)
    );

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // zero wait states: read data is captured in the setup cycle
    assign sel     = decode(paddr);
    assign setup   = psel & ~penable;
    assign sw_wr   = psel & penable & pwrite & (sel != csp_pkg::CSP_SEL_NONE);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (sel == csp_pkg::CSP_SEL_NONE);
    assign dp_inc  = {st_r.data_pointer_high_byte, st_r.data_pointer_low_byte} + 16'h0001;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.stack_wr = 1'b0;
        st_nxt.stack_rd = 1'b0;
        st_nxt.live     = 1'b1;
        if (setup) begin
            st_nxt.prdata = read_word(st_r, sel);
        end
        if (sw_wr) begin
            case (sel)
                csp_pkg::CSP_SEL_STATUS: begin
                    if (pstrb[0]) begin
                        // parity is derived, its bit ignores writes
                        st_nxt.cy = pwdata[`CSP_BIT_CARRY];
                        st_nxt.ac = pwdata[`CSP_BIT_HALF];
                        st_nxt.f0 = pwdata[`CSP_BIT_USER0];
                        st_nxt.rs = pwdata[`CSP_BIT_BANK_HI:`CSP_BIT_BANK_LO];
                        st_nxt.ov = pwdata[`CSP_BIT_RANGE];
                        st_nxt.f1 = pwdata[`CSP_BIT_USER1];
                    end
                end
                csp_pkg::CSP_SEL_MAIN: begin
                    if (pstrb[0]) st_nxt.acc = pwdata[7:0];
                end
                csp_pkg::CSP_SEL_AUX: begin
                    if (pstrb[0]) st_nxt.aux = pwdata[7:0];
                end
                csp_pkg::CSP_SEL_STACK: begin
                    if (pstrb[0]) st_nxt.sp = pwdata[7:0];
                end
                csp_pkg::CSP_SEL_DP_LO: begin
                    if (pstrb[0]) st_nxt.data_pointer_low_byte = pwdata[7:0];
                end
                csp_pkg::CSP_SEL_DP_HI: begin
                    if (pstrb[0]) st_nxt.data_pointer_high_byte = pwdata[7:0];
                end
                csp_pkg::CSP_SEL_DP_16: begin
                    if (pstrb[0]) st_nxt.data_pointer_low_byte = pwdata[7:0];
                    if (pstrb[1]) st_nxt.data_pointer_high_byte = pwdata[15:8];
                end
                default: begin
                    st_nxt.live = 1'b1;
                end
            endcase
        end
        // ------------------------------------------------------------------
        // cpu operations, applied after software so hardware wins
        // ------------------------------------------------------------------
        if (op_valid) begin
            case (op_kind)
                csp_pkg::CSP_OP_ADD, csp_pkg::CSP_OP_ADDC, csp_pkg::CSP_OP_SUBB,
                csp_pkg::CSP_OP_MUL, csp_pkg::CSP_OP_DIV: begin
                    st_nxt.acc = alu_a;
                    st_nxt.aux = alu_b;
                    st_nxt.cy  = alu_cy;
                    st_nxt.ac  = alu_ac;
                    st_nxt.ov  = alu_ov;
                end
                csp_pkg::CSP_OP_PUSH: begin
                    // 8-bit pointer wraps, so the stack spans at most 256 bytes
                    st_nxt.sp         = st_nxt.sp + 8'h01;
                    st_nxt.stack_addr = st_nxt.sp;
                    st_nxt.stack_wr   = 1'b1;
                end
                csp_pkg::CSP_OP_POP: begin
                    st_nxt.stack_addr = st_nxt.sp;
                    st_nxt.stack_rd   = 1'b1;
                    st_nxt.sp         = st_nxt.sp - 8'h01;
                end
                csp_pkg::CSP_OP_CLR_C: st_nxt.cy = 1'b0;
                csp_pkg::CSP_OP_SET_C: st_nxt.cy = 1'b1;
                csp_pkg::CSP_OP_CPL_C: st_nxt.cy = ~st_r.cy;
                csp_pkg::CSP_OP_ANL_C: st_nxt.cy = st_r.cy & op_bit;
                csp_pkg::CSP_OP_ORL_C: st_nxt.cy = st_r.cy | op_bit;
                csp_pkg::CSP_OP_MOV_C: st_nxt.cy = op_bit;
                csp_pkg::CSP_OP_INC_DP: begin
                    {st_nxt.data_pointer_high_byte, st_nxt.data_pointer_low_byte} = dp_inc;
                end
                csp_pkg::CSP_OP_LOAD_DP: begin
                    {st_nxt.data_pointer_high_byte, st_nxt.data_pointer_low_byte} = op_addr16;
                end
                default: begin
                    st_nxt.live = 1'b1;
                end
            endcase
        end
        st_nxt.wreg_addr = bank_addr(st_r.rs, reg_index);
        st_nxt.par       = ^st_nxt.acc;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= '0;
            st_r.sp         <= `CSP_STACK_RESET;
            st_r.acc        <= `CSP_BYTE_RESET;
            st_r.aux        <= `CSP_BYTE_RESET;
            st_r.data_pointer_high_byte        <= `CSP_BYTE_RESET;
            st_r.data_pointer_low_byte        <= `CSP_BYTE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata      = st_r.prdata;
    assign acc_out     = st_r.acc;
    assign aux_out     = st_r.aux;
    assign status_word = pack_status(st_r);
    assign carry_flag  = st_r.cy;
    assign data_pointer_16_out    = {st_r.data_pointer_high_byte, st_r.data_pointer_low_byte};
    assign stack_ptr   = st_r.sp;
    assign stack_addr  = st_r.stack_addr;
    assign stack_wr    = st_r.stack_wr;
    assign stack_rd    = st_r.stack_rd;
    assign wreg_addr   = st_r.wreg_addr;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic is_push;
    logic is_add;
    logic [8:0] add_ref;
    assign is_push = op_valid && (op_kind == csp_pkg::CSP_OP_PUSH) && !sw_wr;
    assign is_add  = op_valid && (op_kind == csp_pkg::CSP_OP_ADD) && !sw_wr;
    assign add_ref = {1'b0, st_r.acc} + {1'b0, op_operand};

    a_push_preinc: assert property (is_push |=> stack_ptr == $past(stack_ptr) + 8'h01
        && stack_addr == stack_ptr && stack_wr) else $error("push did not pre-increment");
    a_stack_reset: assert property (!st_r.live |-> stack_ptr == 8'h07
        && status_word == 8'h00) else $error("stack pointer reset value wrong");
    a_stack_wrap: assert property (is_push && stack_ptr == 8'hff
        |=> stack_ptr == 8'h00) else $error("stack pointer did not wrap");
    a_data_pointer_16_inc: assert property (op_valid && op_kind == csp_pkg::CSP_OP_INC_DP && !sw_wr
        |=> data_pointer_16_out == $past(data_pointer_16_out) + 16'h0001) else $error("data pointer increment wrong");
    a_add_flags: assert property (is_add |=> carry_flag == $past(add_ref[8])
        && acc_out == $past(add_ref[7:0])) else $error("add carry wrong");
    a_bit_and: assert property (op_valid && op_kind == csp_pkg::CSP_OP_ANL_C && !sw_wr
        |=> carry_flag == $past(st_r.cy & op_bit)) else $error("boolean and on carry wrong");
    a_half_carry: assert property (is_add |=> st_r.ac ==
        ($past({1'b0, st_r.acc[3:0]} + {1'b0, op_operand[3:0]}) > 5'h0f))
        else $error("half carry wrong");
    a_bank_map: assert property (##1 wreg_addr ==
        {3'b000, $past(st_r.rs), $past(reg_index)}) else $error("bank address wrong");
    a_add_range: assert property (is_add && st_r.acc == 8'h7f && op_operand == 8'h01
        |=> st_r.ov) else $error("signed overflow missed");
    a_mul_range: assert property (op_valid && op_kind == csp_pkg::CSP_OP_MUL && !sw_wr
        |=> st_r.ov == ({aux_out, acc_out} > 16'h00ff)
        && {aux_out, acc_out} == $past(st_r.acc) * $past(st_r.aux))
        else $error("multiply overflow wrong");
    a_div_zero: assert property (op_valid && op_kind == csp_pkg::CSP_OP_DIV
        && st_r.aux == 8'h00 && !sw_wr |=> st_r.ov && $stable(acc_out))
        else $error("divide by zero not flagged");
    a_range_clear: assert property (is_add && st_r.acc == 8'h00
        |=> !st_r.ov) else $error("overflow not cleared");
    a_parity: assert property (status_word[0] == ^acc_out)
        else $error("parity out of step");
    a_user_flags: assert property (!sw_wr |=> $stable(st_r.f0)
        && $stable(st_r.f1)) else $error("user flag changed by hardware");
    a_status_order: assert property (status_word[7] == carry_flag
        && status_word[4:3] == st_r.rs) else $error("status word layout wrong");

    // worded apart from the datapath, so a slip shared with it still shows
    a_pop_order: assert property (op_valid && op_kind == csp_pkg::CSP_OP_POP && !sw_wr
        |=> stack_ptr == $past(stack_ptr) - 8'h01 && stack_addr == $past(stack_ptr)
        && stack_rd) else $error("pop address or pointer wrong");
    a_subb_borrow: assert property (op_valid && op_kind == csp_pkg::CSP_OP_SUBB
        |=> carry_flag == ($past(st_r.acc) < $past(op_operand)
        || ($past(st_r.acc) == $past(op_operand) && $past(st_r.cy))))
        else $error("subtract borrow wrong");
    a_div_result: assert property (op_valid && op_kind == csp_pkg::CSP_OP_DIV
        && st_r.aux != 8'h00 |=> {8'h00, acc_out} * {8'h00, $past(st_r.aux)}
        + {8'h00, aux_out} == {8'h00, $past(st_r.acc)} && aux_out < $past(st_r.aux))
        else $error("divide quotient or remainder wrong");
    a_load_data_pointer_16: assert property (op_valid && op_kind == csp_pkg::CSP_OP_LOAD_DP
        |=> data_pointer_16_out == $past(op_addr16)) else $error("data pointer load wrong");
    a_carry_set: assert property (op_valid && op_kind == csp_pkg::CSP_OP_SET_C
        |=> carry_flag) else $error("carry set failed");
    a_bool_move: assert property (op_valid && op_kind == csp_pkg::CSP_OP_MOV_C
        |=> carry_flag == $past(op_bit)) else $error("bit move into carry wrong");
    a_stack_load: assert property (sw_wr && sel == csp_pkg::CSP_SEL_STACK && pstrb[0]
        && !op_valid |=> stack_ptr == $past(pwdata[7:0])) else $error("stack write lost");
    a_read_status: assert property (setup && sel == csp_pkg::CSP_SEL_STATUS
        |=> prdata == {24'h000000, $past(status_word)}) else $error("status read wrong");
    a_user_write: assert property (sw_wr && sel == csp_pkg::CSP_SEL_STATUS && pstrb[0]
        |=> status_word[5] == $past(pwdata[5]) && status_word[1] == $past(pwdata[1]))
        else $error("user flag write lost");

    // ------------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------------
    c_push: cover property (is_push ##1 stack_wr);
    c_mul_ovf: cover property (op_valid && op_kind == csp_pkg::CSP_OP_MUL ##1 st_r.ov);
    c_div_zero: cover property (op_valid && op_kind == csp_pkg::CSP_OP_DIV && aux_out == 8'h00);
    c_sw_write: cover property (sw_wr && sel == csp_pkg::CSP_SEL_STATUS);
    c_pop: cover property (op_valid && op_kind == csp_pkg::CSP_OP_POP ##1 stack_rd);
endmodule // csp_top
`default_nettype wire

// file: sim/tb.sv
// self-checking random bench for the cpu status and pointer block
`timescale 1ns/10ps
`include "csp_regs.svh"
`default_nettype none
module tb;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic             op_valid, op_bit, carry_flag, stack_wr, stack_rd, e, c;
    logic [9:0]       paddr;
    logic [31:0]      pwdata, prdata, q;
    logic [15:0]      op_addr16, data_pointer_16_out, p;
    logic [7:0]       op_operand, acc_out, aux_out, status_word, stack_ptr, stack_addr;
    logic [7:0]       wreg_addr, a, b, st;
    logic [2:0]       reg_index;
    logic [10:0]      r;
    csp_pkg::csp_op_e op_kind;
    int               n_mismatch, n_checks;
    logic [7:0]       ix [4] = '{`CSP_IDX_STATUS, `CSP_IDX_MAIN, `CSP_IDX_AUX, `CSP_IDX_STACK};

    csp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind),
        .op_operand(op_operand), .op_bit(op_bit), .op_addr16(op_addr16),
        .reg_index(reg_index), .acc_out(acc_out), .aux_out(aux_out),
        .status_word(status_word), .carry_flag(carry_flag), .data_pointer_16_out(data_pointer_16_out),
        .stack_ptr(stack_ptr), .stack_addr(stack_addr), .stack_wr(stack_wr),
        .stack_rd(stack_rd), .wreg_addr(wreg_addr));

    // ------------------------------------------------------------------
    // tasks and expectation functions
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // results land on the taken edge, so look just after it
    task automatic op(input csp_pkg::csp_op_e k, input logic [7:0] v, input logic bt);
        @(posedge pclk);
        op_valid   <= 1'b1;
        op_kind    <= k;
        op_operand <= v;
        op_bit     <= bt;
        op_addr16  <= 16'($urandom);
        @(posedge pclk);
        op_valid   <= 1'b0;
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // k: 0 add, 1 add with carry, 2 subtract with borrow; returns {cy, half, ovf, sum}
    function automatic logic [10:0] arith(input int k, input logic [7:0] x, y, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        logic       o;
        logic       cc;
        cc = (k == 0) ? 1'b0 : ci;
        s = (k == 2) ? {1'b0, x} - y - cc : {1'b0, x} + y + cc;
        h = (k == 2) ? {1'b0, x[3:0]} - y[3:0] - cc : {1'b0, x[3:0]} + y[3:0] + cc;
        o = (k == 2) ? (x[7] != y[7]) && (s[7] != x[7]) : (x[7] == y[7]) && (s[7] != x[7]);
        return {s[8], h[4], o, s[7:0]};
    endfunction

    task automatic close_out;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        repeat (6000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, op_valid, op_bit, paddr, pwdata} = '0;
        {op_operand, op_addr16, reg_index, c} = '0;
        op_kind = csp_pkg::CSP_OP_NONE;
        void'($urandom(32'hddc5));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ix[j]) begin
            apb(1'b0, ix[j], 32'h0);
            chk(q[15:0], (j == 3) ? 16'h0007 : 16'h0000);
        end
        op(csp_pkg::CSP_OP_PUSH, 8'h00, 1'b0);
        chk({stack_ptr, stack_addr}, 16'h0808);
        chk(16'(stack_wr), 16'h0001);
        apb(1'b1, `CSP_IDX_STACK, 32'hff);
        op(csp_pkg::CSP_OP_PUSH, 8'h00, 1'b0);
        chk({stack_ptr, stack_addr}, 16'h0000);
        op(csp_pkg::CSP_OP_POP, 8'h00, 1'b0);
        chk({stack_ptr, stack_addr}, 16'hff00);
        chk(16'(stack_rd), 16'h0001);
        apb(1'b0, 8'h10, 32'h0);
        chk({e, q[14:0]}, 16'h8000);
        for (int i = 0; i < 24; i++) begin
            // acc 0 with the range flag preset: the add must clear it
            a = (i == 0) ? 8'h7f : (i == 3) ? 8'h00 : 8'($urandom);
            b = (i == 0) ? 8'h01 : 8'($urandom);
            st = 8'($urandom) | ((i == 3) ? 8'h04 : 8'h00);
            apb(1'b1, `CSP_IDX_STATUS, {24'h0, st});
            apb(1'b1, `CSP_IDX_MAIN, {24'h0, a});
            r = arith(i % 3, a, b, st[7]);
            op(csp_pkg::csp_op_e'(i % 3 + 1), b, 1'b0);
            chk(16'(acc_out), 16'(r[7:0]));
            chk(16'(status_word), 16'({r[10:9], st[5:3], r[8], st[1], ^r[7:0]}));
        end
        for (int i = 0; i < 16; i++) begin
            a = 8'($urandom);
            b = (i < 2) ? 8'h00 : 8'($urandom);
            apb(1'b1, `CSP_IDX_MAIN, {24'h0, a});
            apb(1'b1, `CSP_IDX_AUX, {24'h0, b});
            op(i[0] ? csp_pkg::CSP_OP_DIV : csp_pkg::CSP_OP_MUL, 8'h00, 1'b0);
            p = i[0] ? ((b == 0) ? {b, a} : {a % b, a / b}) : a * b;
            e = i[0] ? (b == 0) : (p > 16'h00ff);
            chk({aux_out, acc_out}, p);
            chk(16'({status_word[7:6], status_word[2]}), 16'({2'b00, e}));
        end
        for (int i = 0; i < 24; i++) begin
            e = 1'($urandom);
            op(csp_pkg::csp_op_e'(8 + i % 6), 8'h00, e);
            case (i % 6)
                0: c = 1'b0;
                1: c = 1'b1;
                2: c = ~c;
                3: c = c & e;
                4: c = c | e;
                default: c = e;
            endcase
            chk(16'(carry_flag), 16'(c));
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `CSP_IDX_STATUS, {27'h0, i[1:0], 3'h0});
            reg_index <= 3'($urandom);
            repeat (2) @(posedge pclk);
            #1;
            chk(16'(wreg_addr), 16'({i[1:0], reg_index}));
        end
        p = 16'($urandom);
        apb(1'b1, `CSP_IDX_DP_16, {16'h0, p});
        apb(1'b0, `CSP_IDX_DP_HI, 32'h0);
        chk({q[7:0], data_pointer_16_out[7:0]}, p);
        op(csp_pkg::CSP_OP_LOAD_DP, 8'h00, 1'b0);
        p = op_addr16;
        op(csp_pkg::CSP_OP_INC_DP, 8'h00, 1'b0);
        chk(data_pointer_16_out, p + 16'h0001);
        // second reset mid-run; index parked so no stale bank address is seen
        presetn   <= 1'b0;
        reg_index <= 3'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CSP_IDX_STACK, 32'h0);
        chk(q[15:0], 16'h0007);
        close_out();
    end
endmodule // tb
`default_nettype wire
